// >>> src/dera_ctl.sv
// disk command sequencer with error recovery and alternate tracks
`timescale 1ns/1ns
`default_nettype none
module dera_ctl #(
    parameter int TRK_W = 16,
    parameter int ALT_N = 8,
    parameter logic [15:0] MAX_TRK = 16'h0FFF
) (
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_diag_vld,
    input wire logic i_diag_ram_ok,
    input wire logic i_diag_prom_ok,
    input wire logic i_diag_ecc_ok,
    input wire logic i_cmd_vld,
    input wire logic [7:0] i_cmd_op,
    input wire logic [7:0] i_cmd_ctl,
    input wire logic [TRK_W-1:0] i_cmd_trk,
    input wire logic [TRK_W-1:0] i_cmd_alt,
    input wire logic [TRK_W-1:0] i_alt_lo,
    input wire logic [TRK_W-1:0] i_alt_hi,
    output logic o_cmd_rdy,
    output logic o_done,
    output logic [7:0] o_err_code,
    output logic [TRK_W-1:0] o_sense_trk,
    output logic o_drv_req,
    output logic [2:0] o_drv_op,
    output logic [TRK_W-1:0] o_drv_trk,
    output logic [7:0] o_fill_byte,
    input wire logic i_drv_done,
    input wire logic [7:0] i_drv_err,
    input wire logic i_ecc_uncorr
);
    dera_pkg::dera_state_t state_r, state_nxt;
    logic [7:0] op_r, op_nxt;
    logic [TRK_W-1:0] tgt_r, tgt_nxt;
    logic [TRK_W-1:0] pos_r, pos_nxt;
    logic pos_vld_r, pos_vld_nxt;
    logic recov_r, recov_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic [2:0] stry_r, stry_nxt;
    logic [2:0] dtry_r, dtry_nxt;
    logic done_r, done_nxt;
    logic [7:0] code_r, code_nxt;
    logic [TRK_W-1:0] sense_r, sense_nxt;
    logic [2:0] drv_op_r;
    logic [7:0] fill_r;
    logic fin;
    logic [7:0] fin_code;
    logic look_hit;
    logic look_has_alt;
    logic [TRK_W-1:0] look_alt;
    logic [7:0] asg_code;

    wire idle = state_r == dera_pkg::ST_IDLE;
    wire take = idle && !i_diag_vld && i_cmd_vld;
    wire trk_bad = i_cmd_trk > MAX_TRK[TRK_W-1:0];
    wire cmd_known = i_cmd_op == dera_pkg::CMD_RECAL ||
        i_cmd_op == dera_pkg::CMD_FMT_DRV || i_cmd_op == dera_pkg::CMD_FMT_BAD ||
        i_cmd_op == dera_pkg::CMD_READ || i_cmd_op == dera_pkg::CMD_WRITE ||
        i_cmd_op == dera_pkg::CMD_SEEK || i_cmd_op == dera_pkg::CMD_FMT_ALT;
    wire cmd_xfer = i_cmd_op == dera_pkg::CMD_READ ||
        i_cmd_op == dera_pkg::CMD_WRITE || i_cmd_op == dera_pkg::CMD_SEEK;
    // an alternate addressed directly misses the table and passes through
    wire [TRK_W-1:0] phys = (look_hit && look_has_alt) ? look_alt : i_cmd_trk;
    wire on_trk = pos_vld_r && pos_r == phys;
    wire [7:0] diag_code = !i_diag_ram_ok ? dera_pkg::ERR_RAM :
        !i_diag_prom_ok ? dera_pkg::ERR_PROM :
        !i_diag_ecc_ok ? dera_pkg::ERR_ECC_DIAG : dera_pkg::ERR_NONE;
    // a bare uncorrectable flag from the ECC logic outranks the drive's own code
    wire [7:0] xcode = i_ecc_uncorr ? dera_pkg::ERR_UNCORR : i_drv_err;
    wire is_data = xcode == dera_pkg::ERR_ID_READ || xcode == dera_pkg::ERR_UNCORR ||
        xcode == dera_pkg::ERR_MARK_NF || xcode == dera_pkg::ERR_SECT_NF ||
        xcode == dera_pkg::ERR_CORR;
    wire [4:0] cnt_inc = cnt_r + 5'h01;
    wire over = cnt_inc > dera_pkg::ERR_LIMIT;
    wire asg_stb = take && i_cmd_op == dera_pkg::CMD_FMT_ALT && !trk_bad;
    wire flag_stb = state_r == dera_pkg::ST_FMT_W && i_drv_done &&
        i_drv_err == dera_pkg::ERR_NONE && op_r == dera_pkg::CMD_FMT_BAD;
    wire [2:0] op_sel = (state_nxt == dera_pkg::ST_SEEK) ? dera_pkg::DRV_SEEK :
        (state_nxt == dera_pkg::ST_RECAL) ? dera_pkg::DRV_RECAL :
        (state_nxt == dera_pkg::ST_FMT) ? ((op_nxt == dera_pkg::CMD_FMT_BAD) ?
        dera_pkg::DRV_FMT_BAD : dera_pkg::DRV_FMT) :
        (op_nxt == dera_pkg::CMD_WRITE) ? dera_pkg::DRV_WRITE : dera_pkg::DRV_READ;
    // op code is only loaded with a request so it stands until the next one
    wire drv_go = state_nxt == dera_pkg::ST_SEEK || state_nxt == dera_pkg::ST_RECAL ||
        state_nxt == dera_pkg::ST_XFER || state_nxt == dera_pkg::ST_FMT;

    dera_alt_map #(.N(ALT_N), .TRK_W(TRK_W)) u_alt (
        .i_ref_clk(i_ref_clk),
        .i_srst(i_srst),
        .i_alt_lo(i_alt_lo),
        .i_alt_hi(i_alt_hi),
        .i_flag_stb(flag_stb),
        .i_asg_stb(asg_stb),
        .i_bad_trk(flag_stb ? tgt_r : i_cmd_trk),
        .i_alt_trk(i_cmd_alt),
        .i_look_trk(i_cmd_trk),
        .o_look_hit(look_hit),
        .o_look_has_alt(look_has_alt),
        .o_look_alt(look_alt),
        .o_asg_code(asg_code)
    );

    always_comb begin
        state_nxt = state_r;
        op_nxt = op_r;
        tgt_nxt = tgt_r;
        pos_nxt = pos_r;
        pos_vld_nxt = pos_vld_r;
        recov_nxt = recov_r;
        cnt_nxt = cnt_r;
        stry_nxt = stry_r;
        dtry_nxt = dtry_r;
        sense_nxt = sense_r;
        fin = 1'b0;
        fin_code = dera_pkg::ERR_NONE;
        unique case (state_r)
            dera_pkg::ST_IDLE: begin
                if (i_diag_vld) begin
                    fin = 1'b1;
                    fin_code = diag_code;
                end else if (i_cmd_vld) begin
                    op_nxt = i_cmd_op;
                    recov_nxt = i_cmd_ctl[dera_pkg::RECOV_BIT];
                    cnt_nxt = 5'h00;
                    stry_nxt = 3'h0;
                    dtry_nxt = 3'h0;
                    tgt_nxt = i_cmd_trk;
                    fin = 1'b1;
                    if (!cmd_known) begin
                        fin_code = dera_pkg::ERR_INV_CMD;
                    end else if (trk_bad) begin
                        fin_code = dera_pkg::ERR_ILL_ADDR;
                    end else if (i_cmd_op == dera_pkg::CMD_FMT_ALT) begin
                        fin_code = asg_code;
                    end else if (cmd_xfer && look_hit && !look_has_alt) begin
                        fin_code = dera_pkg::ERR_BAD_TRK;
                    end else if (i_cmd_op == dera_pkg::CMD_RECAL) begin
                        fin = 1'b0;
                        state_nxt = dera_pkg::ST_RECAL;
                    end else if (!cmd_xfer) begin
                        fin = 1'b0;
                        pos_vld_nxt = 1'b0;
                        state_nxt = dera_pkg::ST_FMT;
                    end else begin
                        fin = 1'b0;
                        tgt_nxt = phys;
                        state_nxt = (on_trk && i_cmd_op != dera_pkg::CMD_SEEK) ?
                            dera_pkg::ST_XFER : dera_pkg::ST_SEEK;
                    end
                end
            end
            dera_pkg::ST_SEEK: state_nxt = dera_pkg::ST_SEEK_W;
            dera_pkg::ST_RECAL: state_nxt = dera_pkg::ST_RECAL_W;
            dera_pkg::ST_XFER: state_nxt = dera_pkg::ST_XFER_W;
            dera_pkg::ST_FMT: state_nxt = dera_pkg::ST_FMT_W;
            dera_pkg::ST_SEEK_W: begin
                if (i_drv_done && i_drv_err == dera_pkg::ERR_NONE) begin
                    pos_nxt = tgt_r;
                    pos_vld_nxt = 1'b1;
                    fin = op_r == dera_pkg::CMD_SEEK;
                    state_nxt = dera_pkg::ST_XFER;
                end else if (i_drv_done) begin
                    pos_vld_nxt = 1'b0;
                    cnt_nxt = cnt_inc;
                    fin = 1'b1;
                    fin_code = i_drv_err;
                    if (over) begin
                        fin_code = dera_pkg::ERR_MAX_CNT;
                    end else if (recov_r && i_drv_err == dera_pkg::ERR_SEEK &&
                                 stry_r < dera_pkg::SEEK_RETRY_MAX) begin
                        fin = 1'b0;
                        stry_nxt = stry_r + 3'h1;
                        state_nxt = dera_pkg::ST_RECAL;
                    end
                end
            end
            dera_pkg::ST_RECAL_W: begin
                if (i_drv_done && i_drv_err == dera_pkg::ERR_NONE) begin
                    pos_nxt = '0;
                    pos_vld_nxt = 1'b1;
                    fin = op_r == dera_pkg::CMD_RECAL;
                    state_nxt = dera_pkg::ST_SEEK;
                end else if (i_drv_done) begin
                    pos_vld_nxt = 1'b0;
                    cnt_nxt = cnt_inc;
                    fin = 1'b1;
                    fin_code = over ? dera_pkg::ERR_MAX_CNT : i_drv_err;
                end
            end
            dera_pkg::ST_XFER_W: begin
                if (i_drv_done && xcode == dera_pkg::ERR_NONE) begin
                    fin = 1'b1;
                end else if (i_drv_done) begin
                    cnt_nxt = cnt_inc;
                    fin = 1'b1;
                    fin_code = xcode;
                    if (over) begin
                        fin_code = dera_pkg::ERR_MAX_CNT;
                    end else if (recov_r && is_data && dtry_r == 3'h0) begin
                        fin = 1'b0;
                        dtry_nxt = 3'h1;
                        state_nxt = dera_pkg::ST_XFER;
                    end else if (recov_r && is_data &&
                                 dtry_r <= dera_pkg::DATA_RECAL_MAX) begin
                        fin = 1'b0;
                        dtry_nxt = dtry_r + 3'h1;
                        state_nxt = dera_pkg::ST_RECAL;
                    end
                end
            end
            dera_pkg::ST_FMT_W: begin
                if (i_drv_done && i_drv_err != dera_pkg::ERR_NONE) begin
                    fin = 1'b1;
                    fin_code = i_drv_err;
                    sense_nxt = tgt_r;
                end else if (i_drv_done) begin
                    fin = op_r == dera_pkg::CMD_FMT_BAD ||
                        tgt_r == MAX_TRK[TRK_W-1:0];
                    tgt_nxt = tgt_r + {{(TRK_W-1){1'b0}}, 1'b1};
                    state_nxt = dera_pkg::ST_FMT;
                end
            end
        endcase
        done_nxt = fin;
        code_nxt = fin ? fin_code : code_r;
        if (fin) begin
            state_nxt = dera_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            state_r <= dera_pkg::ST_IDLE;
            op_r <= 8'h00;
            tgt_r <= '0;
            pos_r <= '0;
            pos_vld_r <= 1'b0;
            recov_r <= 1'b0;
            cnt_r <= 5'h00;
            stry_r <= 3'h0;
            dtry_r <= 3'h0;
            done_r <= 1'b0;
            code_r <= dera_pkg::ERR_NONE;
            sense_r <= '0;
            drv_op_r <= dera_pkg::DRV_SEEK;
            fill_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            op_r <= op_nxt;
            tgt_r <= tgt_nxt;
            pos_r <= pos_nxt;
            pos_vld_r <= pos_vld_nxt;
            recov_r <= recov_nxt;
            cnt_r <= cnt_nxt;
            stry_r <= stry_nxt;
            dtry_r <= dtry_nxt;
            done_r <= done_nxt;
            code_r <= code_nxt;
            sense_r <= sense_nxt;
            drv_op_r <= drv_go ? op_sel : drv_op_r;
            fill_r <= (state_nxt == dera_pkg::ST_FMT) ? dera_pkg::FILL_BYTE : 8'h00;
        end
    end

    assign o_cmd_rdy = idle;
    assign o_drv_req = state_r == dera_pkg::ST_SEEK || state_r == dera_pkg::ST_RECAL ||
        state_r == dera_pkg::ST_XFER || state_r == dera_pkg::ST_FMT;
    assign o_done = done_r;
    assign o_err_code = code_r;
    assign o_sense_trk = sense_r;
    assign o_drv_op = drv_op_r;
    assign o_drv_trk = (state_r == dera_pkg::ST_RECAL) ? '0 : tgt_r;
    assign o_fill_byte = fill_r;

    wire xw_err = state_r == dera_pkg::ST_XFER_W && i_drv_done &&
        xcode != dera_pkg::ERR_NONE;

    property p_prom;
        @(posedge i_ref_clk) disable iff (i_srst)
        idle && i_diag_vld && i_diag_ram_ok && !i_diag_prom_ok |=>
            o_done && o_err_code == 8'h31;
    endproperty
    a_prom: assert property (p_prom) else $error("checksum code wrong");
    property p_eccd;
        @(posedge i_ref_clk) disable iff (i_srst)
        idle && i_diag_vld && i_diag_ram_ok && i_diag_prom_ok && !i_diag_ecc_ok
            |=> o_done && o_err_code == 8'h32;
    endproperty
    a_eccd: assert property (p_eccd) else $error("ecc diag code wrong");
    property p_abort;
        @(posedge i_ref_clk) disable iff (i_srst)
        xw_err && cnt_r == 5'h14 |=> o_done && o_err_code == 8'h33;
    endproperty
    a_abort: assert property (p_abort) else $error("no abort at limit");
    property p_norecov;
        @(posedge i_ref_clk) disable iff (i_srst)
        xw_err && !recov_r |=> o_done && o_cmd_rdy;
    endproperty
    a_norecov: assert property (p_norecov) else $error("retry while off");
    property p_reread;
        @(posedge i_ref_clk) disable iff (i_srst)
        xw_err && recov_r && is_data && dtry_r == 3'h0 && !over |=>
            o_drv_req && o_drv_op == 3'h2 ##1 !o_drv_req;
    endproperty
    a_reread: assert property (p_reread) else $error("no reread");
    property p_seek_lim;
        @(posedge i_ref_clk) disable iff (i_srst)
        state_r == dera_pkg::ST_SEEK_W && i_drv_done && i_drv_err == 8'h15 &&
            stry_r == 3'h4 |=> o_done && $stable(stry_r);
    endproperty
    a_seek_lim: assert property (p_seek_lim) else $error("fifth reseek");
    property p_cnt;
        @(posedge i_ref_clk) disable iff (i_srst) cnt_r <= 5'h15;
    endproperty
    a_cnt: assert property (p_cnt) else $error("error count past limit");
    property p_redir;
        @(posedge i_ref_clk) disable iff (i_srst)
        take && cmd_xfer && look_hit && look_has_alt && !trk_bad && !on_trk |=>
            o_drv_req && o_drv_trk == $past(look_alt);
    endproperty
    a_redir: assert property (p_redir) else $error("no redirect");
    property p_stay;
        @(posedge i_ref_clk) disable iff (i_srst)
        take && i_cmd_op == dera_pkg::CMD_READ && cmd_known && !trk_bad &&
            !(look_hit && !look_has_alt) && on_trk |=> o_drv_op == 3'h2;
    endproperty
    a_stay: assert property (p_stay) else $error("needless reseek");
    property p_sense;
        @(posedge i_ref_clk) disable iff (i_srst)
        state_r == dera_pkg::ST_FMT_W && i_drv_done && i_drv_err != 8'h00 |=>
            o_done && o_sense_trk == $past(tgt_r);
    endproperty
    a_sense: assert property (p_sense) else $error("sense track wrong");
    property p_recal;
        @(posedge i_ref_clk) disable iff (i_srst)
        state_r == dera_pkg::ST_RECAL_W && i_drv_done && i_drv_err == 8'h00 |=>
            pos_vld_r && pos_r == '0;
    endproperty
    a_recal: assert property (p_recal) else $error("recal not at zero");
    property p_fill;
        @(posedge i_ref_clk) disable iff (i_srst)
        o_drv_req && o_drv_op == 3'h4 |-> o_fill_byte == 8'h6C;
    endproperty
    a_fill: assert property (p_fill) else $error("fill byte wrong");
    c_redir: cover property (@(posedge i_ref_clk) take && look_has_alt);
    c_recal_seq: cover property (@(posedge i_ref_clk) dtry_r == 3'h4);
    c_abort: cover property (@(posedge i_ref_clk) o_done && o_err_code == 8'h33);
endmodule : dera_ctl
`default_nettype wire

// >>> src/dera_pkg.sv
// constants and types shared by the disk error recovery controller
package dera_pkg;
    // completion codes
    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_NO_INDEX = 8'h01;
    localparam logic [7:0] ERR_NO_SEEK_CMP = 8'h02;
    localparam logic [7:0] ERR_WR_FAULT = 8'h03;
    localparam logic [7:0] ERR_NOT_READY = 8'h04;
    localparam logic [7:0] ERR_TRK0_NF = 8'h06;
    localparam logic [7:0] ERR_SEEKING = 8'h08;
    localparam logic [7:0] ERR_ID_READ = 8'h10;
    localparam logic [7:0] ERR_UNCORR = 8'h11;
    localparam logic [7:0] ERR_MARK_NF = 8'h12;
    localparam logic [7:0] ERR_SECT_NF = 8'h14;
    localparam logic [7:0] ERR_SEEK = 8'h15;
    localparam logic [7:0] ERR_CORR = 8'h18;
    localparam logic [7:0] ERR_BAD_TRK = 8'h19;
    localparam logic [7:0] ERR_FORMAT = 8'h1A;
    localparam logic [7:0] ERR_ALT_USED = 8'h1D;
    localparam logic [7:0] ERR_ALT_NF = 8'h1E;
    localparam logic [7:0] ERR_ALT_SAME = 8'h1F;
    localparam logic [7:0] ERR_INV_CMD = 8'h20;
    localparam logic [7:0] ERR_ILL_ADDR = 8'h21;
    localparam logic [7:0] ERR_ILL_PARAM = 8'h22;
    localparam logic [7:0] ERR_RAM = 8'h30;
    localparam logic [7:0] ERR_PROM = 8'h31;
    localparam logic [7:0] ERR_ECC_DIAG = 8'h32;
    localparam logic [7:0] ERR_MAX_CNT = 8'h33;
    // host commands
    localparam logic [7:0] CMD_RECAL = 8'h01;
    localparam logic [7:0] CMD_FMT_DRV = 8'h04;
    localparam logic [7:0] CMD_FMT_BAD = 8'h07;
    localparam logic [7:0] CMD_READ = 8'h08;
    localparam logic [7:0] CMD_WRITE = 8'h0A;
    localparam logic [7:0] CMD_SEEK = 8'h0B;
    localparam logic [7:0] CMD_FMT_ALT = 8'h0E;
    // recovery enable position in control byte 5
    localparam int RECOV_BIT = 7;
    localparam logic [4:0] ERR_LIMIT = 5'h14;
    localparam logic [2:0] DATA_RECAL_MAX = 3'h3;
    localparam logic [2:0] SEEK_RETRY_MAX = 3'h4;
    localparam logic [7:0] FILL_BYTE = 8'h6C;
    // operations requested from the drive
    localparam logic [2:0] DRV_SEEK = 3'h0;
    localparam logic [2:0] DRV_RECAL = 3'h1;
    localparam logic [2:0] DRV_READ = 3'h2;
    localparam logic [2:0] DRV_WRITE = 3'h3;
    localparam logic [2:0] DRV_FMT = 3'h4;
    localparam logic [2:0] DRV_FMT_BAD = 3'h5;

    typedef enum logic [3:0] {
        ST_IDLE, ST_SEEK, ST_SEEK_W, ST_RECAL, ST_RECAL_W,
        ST_XFER, ST_XFER_W, ST_FMT, ST_FMT_W
    } dera_state_t;
endpackage : dera_pkg

// >>> src/dera_alt_map.sv
// table of flagged defective tracks and their alternates
`timescale 1ns/1ns
`default_nettype none
module dera_alt_map #(
    parameter int N = 8,
    parameter int TRK_W = 16
) (
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic [TRK_W-1:0] i_alt_lo,
    input wire logic [TRK_W-1:0] i_alt_hi,
    input wire logic i_flag_stb,
    input wire logic i_asg_stb,
    input wire logic [TRK_W-1:0] i_bad_trk,
    input wire logic [TRK_W-1:0] i_alt_trk,
    input wire logic [TRK_W-1:0] i_look_trk,
    output logic o_look_hit,
    output logic o_look_has_alt,
    output logic [TRK_W-1:0] o_look_alt,
    output logic [7:0] o_asg_code
);
    logic [TRK_W-1:0] bad_r [N];
    logic [TRK_W-1:0] alt_r [N];
    logic [N-1:0] used_r;
    logic [N-1:0] altv_r;
    wire [N-1:0] look_m;
    wire [N-1:0] bad_m;
    wire [N-1:0] alt_busy;
    wire [N-1:0] free = ~used_r;
    wire [N-1:0] first_free = free & (~free + {{(N-1){1'b0}}, 1'b1});
    wire [N-1:0] wr_sel = (|bad_m) ? bad_m : first_free;
    wire full = ~(|bad_m) && ~(|free);
    wire wr_en = i_flag_stb || (i_asg_stb && o_asg_code == dera_pkg::ERR_NONE);

    // alternates only come from the range the host set up beforehand
    wire out_rng = (i_alt_trk < i_alt_lo) || (i_alt_trk > i_alt_hi);

    assign o_asg_code = (i_alt_trk == i_bad_trk) ? dera_pkg::ERR_ALT_SAME :
                        out_rng ? dera_pkg::ERR_ALT_NF :
                        (|alt_busy) ? dera_pkg::ERR_ALT_USED :
                        full ? dera_pkg::ERR_ILL_PARAM : dera_pkg::ERR_NONE;

    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_ent
            assign look_m[gi] = used_r[gi] && bad_r[gi] == i_look_trk;
            assign bad_m[gi] = used_r[gi] && bad_r[gi] == i_bad_trk;
            assign alt_busy[gi] = used_r[gi] && (bad_r[gi] == i_alt_trk ||
                (altv_r[gi] && alt_r[gi] == i_alt_trk));
            always_ff @(posedge i_ref_clk) begin
                if (i_srst) begin
                    used_r[gi] <= 1'b0;
                    altv_r[gi] <= 1'b0;
                end else if (wr_en && wr_sel[gi]) begin
                    used_r[gi] <= 1'b1;
                    altv_r[gi] <= i_asg_stb;
                end
            end
            always_ff @(posedge i_ref_clk) begin
                if (wr_en && wr_sel[gi]) begin
                    bad_r[gi] <= i_bad_trk;
                    alt_r[gi] <= i_alt_trk;
                end
            end
        end
    endgenerate

    // entries never duplicate a bad track, so at most one matches
    always_comb begin
        o_look_has_alt = 1'b0;
        o_look_alt = i_look_trk;
        for (int i = 0; i < N; i++) begin
            if (look_m[i]) begin
                o_look_has_alt = altv_r[i];
                o_look_alt = alt_r[i];
            end
        end
    end
    assign o_look_hit = |look_m;
endmodule : dera_alt_map
`default_nettype wire

// >>> test/dera_drv_model.sv
// behavioural fixed disk drive answering the sequencer
`timescale 1ns/1ns
`default_nettype none
module dera_drv_model (
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_req,
    input wire logic [2:0] i_op,
    input wire logic [15:0] i_trk,
    input wire logic [2:0] i_fail_op,
    input wire logic [15:0] i_fail_trk,
    input wire logic [7:0] i_fail_code,
    output logic o_done,
    output logic [7:0] o_err,
    output logic [15:0] o_pos
);
    logic busy_r, slow_r, hit;
    logic [1:0] wait_r;
    logic [2:0] op_r;
    logic [15:0] trk_r;
    // a set code fails every matching op; all ones matches any track
    assign hit = i_fail_code != 8'h00 && op_r == i_fail_op &&
        (i_fail_trk == 16'hFFFF || i_fail_trk == trk_r);
    always @(posedge i_ref_clk) begin
        o_done <= 1'b0;
        o_err <= ~o_err; // status is not held between answers
        if (i_srst) begin
            busy_r <= 1'b0;
            slow_r <= 1'b0;
            o_err <= 8'h00;
        end else if (i_req) begin
            busy_r <= 1'b1;
            wait_r <= slow_r ? 2'h3 : 2'h0; // prompt and slow in turn
            slow_r <= ~slow_r;
            op_r <= i_op;
            trk_r <= i_trk;
        end else if (busy_r && wait_r != 2'h0) begin
            wait_r <= wait_r - 2'h1;
        end else if (busy_r) begin
            busy_r <= 1'b0;
            o_done <= 1'b1;
            o_err <= hit ? i_fail_code : 8'h00;
            if (!hit && op_r == dera_pkg::DRV_RECAL) o_pos <= 16'h0000;
            if (!hit && op_r == dera_pkg::DRV_SEEK) o_pos <= trk_r;
        end
    end
endmodule : dera_drv_model
`default_nettype wire

// >>> test/disk_error_recovery_alt_track_tb.sv
// self-checking bench for the disk command sequencer
`timescale 1ns/1ns
`default_nettype none
module disk_error_recovery_alt_track_tb;
    logic clk = 1'b0, srst = 1'b1, dvld = 1'b0, ram = 1'b1, prom = 1'b1;
    logic ecc = 1'b1, cvld = 1'b0, rdy, done, req, ddone;
    logic [7:0] op = 8'h00, ctl = 8'h80, code, fill, derr, fcode = 8'h00;
    logic [15:0] trk = 16'h0, alt = 16'h0, sense, dtrk, pos;
    logic [15:0] lo = 16'h0002, hi = 16'h0003;
    logic [15:0] ftrk = 16'hFFFF;
    logic [2:0] dop, fop = 3'h0;
    logic [15:0] lt[$];
    logic uen = 1'b0;
    wire unc = uen & ddone;
    int mismatches = 0, cmp_count = 0;
    dera_ctl #(.MAX_TRK(16'h0003)) dut (.i_ref_clk(clk), .i_srst(srst),
        .i_diag_vld(dvld), .i_diag_ram_ok(ram), .i_diag_prom_ok(prom),
        .i_diag_ecc_ok(ecc), .i_cmd_vld(cvld), .i_cmd_op(op), .i_cmd_ctl(ctl),
        .i_cmd_trk(trk), .i_cmd_alt(alt), .i_alt_lo(lo), .i_alt_hi(hi),
        .o_cmd_rdy(rdy), .o_done(done), .o_err_code(code),
        .o_sense_trk(sense), .o_drv_req(req), .o_drv_op(dop),
        .o_drv_trk(dtrk), .o_fill_byte(fill), .i_drv_done(ddone),
        .i_drv_err(derr), .i_ecc_uncorr(unc));
    dera_drv_model drv (.i_ref_clk(clk), .i_srst(srst), .i_req(req),
        .i_op(dop), .i_trk(dtrk), .i_fail_op(fop), .i_fail_trk(ftrk),
        .i_fail_code(fcode), .o_done(ddone), .o_err(derr), .o_pos(pos));
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    always @(posedge clk) begin
        if (req === 1'b1) begin
            lt.push_back(dtrk);
            if (dop === dera_pkg::DRV_FMT) chk({8'h00, fill}, 16'h006C);
        end
    end
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    task automatic waitd;
        int k;
        k = 0;
        while (done !== 1'b1 && k < 3000) begin
            @(negedge clk);
            k++;
        end
        if (done !== 1'b1) begin
            mismatches++;
            give_verdict();
        end
    endtask : waitd
    task automatic cmd(input logic [7:0] o, input logic [15:0] t, a);
        lt.delete();
        @(negedge clk);
        op = o;
        trk = t;
        alt = a;
        cvld = 1'b1;
        @(negedge clk);
        cvld = 1'b0;
        waitd();
    endtask : cmd
    task automatic t_diag;
        logic [7:0] ex[4] = '{8'h30, 8'h31, 8'h32, 8'h00};
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            {ram, prom, ecc} = {i != 0, i != 1, i != 2};
            dvld = 1'b1;
            @(negedge clk);
            dvld = 1'b0;
            waitd();
            chk(code, ex[i]);
        end
        cmd(8'hFF, 16'h0000, 16'h0000);
        chk(code, 8'h20);
        cmd(dera_pkg::CMD_READ, 16'h0004, 16'h0000);
        chk(code, 8'h21);
        $display("diag and immediate codes done");
    endtask : t_diag
    task automatic t_rec;
        logic [7:0] dc[5] = '{8'h10, 8'h11, 8'h12, 8'h14, 8'h18};
        fop = dera_pkg::DRV_READ;
        fcode = 8'h11;
        ctl = 8'h00;
        cmd(dera_pkg::CMD_READ, 16'h0000, 16'h0000);
        chk(code, 8'h11);
        chk(16'(lt.size()), 16'h0002);
        fcode = 8'h00;
        uen = 1'b1;
        cmd(dera_pkg::CMD_READ, 16'h0000, 16'h0000);
        chk(code, 8'h11);
        uen = 1'b0;
        ctl = 8'h80;
        for (int i = 0; i < 5; i++) begin
            fcode = dc[i];
            cmd(dera_pkg::CMD_READ, 16'((i + 1) % 2), 16'h0000);
            chk(code, dc[i]);
            chk(16'(lt.size()), 16'h000C);
        end
        fop = dera_pkg::DRV_SEEK;
        fcode = 8'h15;
        cmd(dera_pkg::CMD_READ, 16'h0000, 16'h0000);
        chk(code, 8'h15);
        chk(16'(lt.size()), 16'h0009);
        fcode = 8'h00;
        cmd(dera_pkg::CMD_RECAL, 16'h0002, 16'h0000);
        chk({13'h0, dop}, 16'h0001);
        chk(pos, 16'h0000);
        $display("recovery done");
    endtask : t_rec
    task automatic t_fmt;
        cmd(dera_pkg::CMD_FMT_DRV, 16'h0000, 16'h0000);
        chk(16'(lt.size()), 16'h0004);
        fop = dera_pkg::DRV_FMT;
        ftrk = 16'h0002;
        fcode = 8'h1A;
        cmd(dera_pkg::CMD_FMT_DRV, 16'h0000, 16'h0000);
        chk(code, 8'h1A);
        chk(sense, 16'h0002);
        fcode = 8'h00;
        cmd(dera_pkg::CMD_FMT_BAD, sense, 16'h0000);
        cmd(dera_pkg::CMD_FMT_DRV, sense + 16'h0001, 16'h0000);
        chk(code, 8'h00);
        $display("format done");
    endtask : t_fmt
    task automatic t_alt;
        cmd(dera_pkg::CMD_FMT_BAD, 16'h0001, 16'h0000);
        cmd(dera_pkg::CMD_READ, 16'h0001, 16'h0000);
        chk(code, 8'h19);
        cmd(dera_pkg::CMD_FMT_ALT, 16'h0002, 16'h0002);
        chk(code, 8'h1F);
        cmd(dera_pkg::CMD_FMT_ALT, 16'h0002, 16'h0000);
        chk(code, 8'h1E);
        cmd(dera_pkg::CMD_FMT_ALT, 16'h0002, 16'h0003);
        chk(code, 8'h00);
        cmd(dera_pkg::CMD_FMT_ALT, 16'h0001, 16'h0003);
        chk(code, 8'h1D);
        cmd(dera_pkg::CMD_READ, 16'h0002, 16'h0000);
        chk(lt[0], 16'h0003);
        cmd(dera_pkg::CMD_READ, 16'h0002, 16'h0000);
        chk(16'(lt.size()), 16'h0001);
        cmd(dera_pkg::CMD_READ, 16'h0003, 16'h0000);
        chk(dtrk, 16'h0003);
        chk(code, 8'h00);
        $display("alternate tracks done");
    endtask : t_alt
    initial begin
        repeat (12) @(negedge clk);
        srst = 1'b0;
        t_diag();
        t_rec();
        t_fmt();
        t_alt();
        give_verdict();
    end
endmodule : disk_error_recovery_alt_track_tb
`default_nettype wire
